// ===== verilog/ext_pin_irq.sv
/*
  External pin interrupt latch top: register port, request latch, mask,
  pin function and pullup controls, event interrupt.
  Assumes a plain one-cycle register port on core_clk_i.
*/
// Our own choice: the plain strobed port.
//
// Contract
// - enable bit gives pin to interrupt
// - falling edge sets request latch
// - vector fetch acknowledge clears latch
// - ack write of one clears latch
// - reset clears latch and mode
// - edge mode: ack clears at once
// - level mode: ack and pin high
// - mask blocks request, latch unaffected
// - edges after ack set latch again
// - vector at FFFA high, FFFB low
// - pending flag bit 3 ignores mask
// - branch sees pin; port bit reads zero
// - pullup on unless disable bit set
// - break clear enabled: ack clears latch
// - break clear disabled: ack write ignored in break
// - ack bit write-only, reads zero
// - mask bit 1, reset clear
// - mode bit 0; bits 7-4 zero
`timescale 1ns/100ps
`include "ext_irq_consts.svh"
module ext_pin_irq (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  // register port
  input  wire ext_irq_pkg::reg_addr_t reg_addr_i,
  input  wire ext_irq_pkg::reg_byte_t reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output ext_irq_pkg::reg_byte_t  reg_rdata_o,
  // pin and cpu side
  input  wire logic               irq_n_pin_i,
  input  wire logic               vector_fetch_ack_i,
  input  wire logic               break_state_i,
  output logic                    cpu_irq_req_o,
  output logic [15:0]             vector_high_addr_o,
  output logic [15:0]             vector_low_addr_o,
  output logic                    pullup_enable_o,
  output logic                    pin_function_enable_o,
  output logic                    branch_pin_level_o,
  output logic                    port_a_bit_two_force_zero_o,
  // event interrupt
  output logic                    irq_o
);
  import ext_irq_pkg::*;

  reg_byte_t   ctrl_r;
  reg_byte_t   cfg_r;
  reg_byte_t   brk_ctrl_r;
  logic [1:0]  ev_status_r;
  logic [1:0]  ev_mask_r;
  logic        pending;
  logic        ack_wr;
  logic        ack_eff;
  logic        wr_ctrl;
  logic        fn_en;
  logic        mask;
  logic        mode;
  logic [1:0]  ev_set;
  reg_byte_t   rdata_nxt;

  pin_sample_if pin ();

  assign fn_en   = cfg_r[`BIT_PIN_FN_ENABLE];
  assign mask    = ctrl_r[`BIT_REQUEST_MASK];
  assign mode    = ctrl_r[`BIT_TRIGGER_MODE];
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `ADDR_EXT_INT_STATUS_CONTROL);
  assign ack_wr  = wr_ctrl && reg_wdata_i[`BIT_ACK];

  // ----------------------------------------------------------------------------
  // acknowledge qualification
  // ----------------------------------------------------------------------------
  // software ack in break only when break clear is enabled
  assign ack_eff = vector_fetch_ack_i
                 | (ack_wr & (~break_state_i | brk_ctrl_r[`BIT_BREAK_CLEAR_EN]));

  // ----------------------------------------------------------------------------
  // pin front end and latch
  // ----------------------------------------------------------------------------
  irq_pin_sync u_sync (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .irq_n_pin_i (irq_n_pin_i),
    .enable_i    (fn_en),
    .sample      (pin.src)
  );

  irq_req_latch u_latch (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (fn_en),
    .level_mode_i (mode),
    .ack_i        (ack_eff),
    .sample       (pin.dst),
    .pending_o    (pending)
  );

  // ----------------------------------------------------------------------------
  // status/control register
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `RST_EXT_INT_STATUS_CONTROL;
    end else if (wr_ctrl) begin
      ctrl_r <= {6'h00, reg_wdata_i[`BIT_REQUEST_MASK], reg_wdata_i[`BIT_TRIGGER_MODE]};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= `RST_CONFIG_REG_TWO;
    end else if (reg_wr_i && reg_addr_i == `ADDR_CONFIG_REG_TWO) begin
      cfg_r <= {6'h00, reg_wdata_i[1:0]};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      brk_ctrl_r <= `RST_BREAK_FLAG_CONTROL_REG;
    end else if (reg_wr_i && reg_addr_i == `ADDR_BREAK_FLAG_CONTROL_REG) begin
      brk_ctrl_r <= {reg_wdata_i[`BIT_BREAK_CLEAR_EN], 7'h00};
    end
  end

  // ----------------------------------------------------------------------------
  // event status write one to clear, set wins; mask plain write
  // ----------------------------------------------------------------------------
  assign ev_set[`BIT_EV_EDGE]    = pin.fall;
  assign ev_set[`BIT_EV_SERVICE] = vector_fetch_ack_i;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ev_status_r <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == `ADDR_IRQ_STATUS) begin
      ev_status_r <= (ev_status_r & ~reg_wdata_i[1:0]) | ev_set;
    end else begin
      ev_status_r <= ev_status_r | ev_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ev_mask_r <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == `ADDR_IRQ_MASK) begin
      ev_mask_r <= reg_wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // read path, one cycle latency
  // ----------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr_i)
      `ADDR_EXT_INT_STATUS_CONTROL: begin
        // ack reads zero; upper nibble zero
        rdata_nxt = {4'h0, pending, 1'b0, mask, mode};
      end
      `ADDR_CONFIG_REG_TWO:         rdata_nxt = cfg_r;
      `ADDR_BREAK_FLAG_CONTROL_REG: rdata_nxt = brk_ctrl_r;
      `ADDR_IRQ_STATUS:             rdata_nxt = {6'h00, ev_status_r};
      `ADDR_IRQ_MASK:               rdata_nxt = {6'h00, ev_mask_r};
      default:                      rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // cpu side and pin control outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cpu_irq_req_o               <= 1'b0;
      vector_high_addr_o          <= `VECTOR_ADDR_HIGH;
      vector_low_addr_o           <= `VECTOR_ADDR_LOW;
      pullup_enable_o             <= 1'b1;
      pin_function_enable_o       <= 1'b0;
      branch_pin_level_o          <= 1'b1;
      port_a_bit_two_force_zero_o <= 1'b0;
      irq_o                       <= 1'b0;
    end else begin
      cpu_irq_req_o               <= pending & ~mask;
      vector_high_addr_o          <= `VECTOR_ADDR_HIGH;
      vector_low_addr_o           <= `VECTOR_ADDR_LOW;
      pullup_enable_o             <= ~cfg_r[`BIT_PULLUP_DISABLE];
      pin_function_enable_o       <= fn_en;
      branch_pin_level_o          <= fn_en ? pin.level : 1'b1;
      port_a_bit_two_force_zero_o <= fn_en;
      irq_o                       <= |((ev_status_r | ev_set) & ev_mask_r);
    end
  end
endmodule

// ===== common/ext_irq_consts.svh
/*
  Offsets, field positions, reset values and vector addresses for the external
  pin interrupt latch. Assumes inclusion by bare name from the design files.
*/
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_EXT_INT_STATUS_CONTROL 8'h1D
`define ADDR_CONFIG_REG_TWO         8'h1E
`define ADDR_BREAK_FLAG_CONTROL_REG 8'h20
`define ADDR_IRQ_STATUS             8'h21
`define ADDR_IRQ_MASK               8'h22

// ----------------------------------------------------------------------------
// status/control fields
// ----------------------------------------------------------------------------
`define BIT_TRIGGER_MODE  0
`define BIT_REQUEST_MASK  1
`define BIT_ACK           2
`define BIT_PENDING_FLAG  3

// ----------------------------------------------------------------------------
// config two fields
// ----------------------------------------------------------------------------
`define BIT_PULLUP_DISABLE 0
`define BIT_PIN_FN_ENABLE  1

// ----------------------------------------------------------------------------
// break flag control fields
// ----------------------------------------------------------------------------
`define BIT_BREAK_CLEAR_EN 7

// ----------------------------------------------------------------------------
// event status fields
// ----------------------------------------------------------------------------
`define BIT_EV_EDGE    0
`define BIT_EV_SERVICE 1

// ----------------------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------------------
`define RST_EXT_INT_STATUS_CONTROL 8'h00
`define RST_CONFIG_REG_TWO         8'h00
`define RST_BREAK_FLAG_CONTROL_REG 8'h00
`define VECTOR_ADDR_HIGH           16'hFFFA
`define VECTOR_ADDR_LOW            16'hFFFB

`endif

// ===== common/ext_irq_pkg.sv
/*
  Types shared by the external pin interrupt latch modules.
  Assumes the consts header is compiled alongside.
*/
package ext_irq_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;

  typedef enum logic [1:0] {
    LATCH_IDLE,
    LATCH_HELD,
    LATCH_WAIT_HIGH
  } latch_state_t;

endpackage

// ===== common/pin_sample_if.sv
/*
  Interface carrying the synchronised pin level and its falling edge event
  from the pin front end to the latch logic. Assumes one clock domain.
*/
`timescale 1ns/100ps
interface pin_sample_if;
  logic level;
  logic fall;

  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// ===== verilog/irq_pin_sync.sv
/*
  Two-flop synchroniser and falling edge detector for the interrupt pin.
  Assumes the pin is asynchronous to core_clk_i.
*/
`timescale 1ns/100ps
module irq_pin_sync (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // pin and qualifier
  input  wire logic irq_n_pin_i,
  input  wire logic enable_i,
  // result
  pin_sample_if.src sample
);
  import ext_irq_pkg::*;

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ----------------------------------------------------------------------------
  // synchroniser, idle high
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= irq_n_pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign sample.level = sync_r;
  assign sample.fall  = enable_i & prev_r & ~sync_r;
endmodule

// ===== verilog/irq_req_latch.sv
/*
  Request latch with edge-only and edge-plus-level modes.
  Assumes ack_i is already qualified by break control.
*/
`timescale 1ns/100ps
module irq_req_latch (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // controls
  input  wire logic enable_i,
  input  wire logic level_mode_i,
  input  wire logic ack_i,
  // pin
  pin_sample_if.dst sample,
  // state
  output logic      pending_o
);
  import ext_irq_pkg::*;

  latch_state_t state_r;
  latch_state_t state_nxt;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LATCH_IDLE: begin
        if (sample.fall) begin
          state_nxt = LATCH_HELD;
        end
      end
      LATCH_HELD: begin
        if (ack_i) begin
          if (level_mode_i && !sample.level && enable_i) begin
            state_nxt = LATCH_WAIT_HIGH;
          end else begin
            state_nxt = LATCH_IDLE;
          end
        end
      end
      LATCH_WAIT_HIGH: begin
        if (!level_mode_i || sample.level || !enable_i) begin
          state_nxt = LATCH_IDLE;
        end
      end
    endcase
    if (sample.fall && state_nxt == LATCH_IDLE) begin
      state_nxt = LATCH_HELD;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= LATCH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pending_o = (state_r != LATCH_IDLE);
endmodule

// ===== tb/ext_pin_irq_props.sv
/* checker on the ports of ext_pin_irq
   assumes one clock, sync active-low reset */
`timescale 1ns/100ps
module ext_pin_irq_props (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire ext_irq_pkg::reg_addr_t reg_addr_i,
  input wire ext_irq_pkg::reg_byte_t reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire ext_irq_pkg::reg_byte_t reg_rdata_o,
  input wire logic                   cpu_irq_req_o,
  input wire logic [15:0]            vector_high_addr_o,
  input wire logic [15:0]            vector_low_addr_o,
  input wire logic                   pullup_enable_o,
  input wire logic                   pin_function_enable_o,
  input wire logic                   branch_pin_level_o,
  input wire logic                   port_a_bit_two_force_zero_o,
  input wire logic                   irq_o
);
  import ext_irq_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // write then quiet
  // ----
  sequence cfg_wr_s;
    reg_wr_i && reg_addr_i == 8'h1E ##1 !(reg_wr_i && reg_addr_i == 8'h1E);
  endsequence
  sequence mask_wr_s;
    reg_wr_i && reg_addr_i == 8'h1D && reg_wdata_i[1] ##1 !(reg_wr_i && reg_addr_i == 8'h1D);
  endsequence
  AST_VEC_HI: assert property (vector_high_addr_o == 16'hFFFA)
    else $error("vector high address wrong");
  AST_VEC_LO: assert property (vector_low_addr_o == 16'hFFFB)
    else $error("vector low address wrong");
  AST_PULLUP: assert property (cfg_wr_s |=> pullup_enable_o == !$past(reg_wdata_i[0], 2))
    else $error("pullup enable does not follow config");
  AST_FN_EN: assert property (cfg_wr_s |=> pin_function_enable_o == $past(reg_wdata_i[1], 2))
    else $error("pin function enable does not follow config");
  AST_PORTA: assert property (cfg_wr_s |=> port_a_bit_two_force_zero_o == $past(reg_wdata_i[1], 2))
    else $error("port bit force differs from enable");
  AST_BRANCH: assert property (!pin_function_enable_o && !$past(pin_function_enable_o)
    |-> branch_pin_level_o)
    else $error("branch level not high while disabled");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  AST_RD_FIELD: assert property ($past(reg_rd_i && reg_addr_i == 8'h1D)
    |-> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2])
    else $error("status reserved or ack bit read nonzero");
  AST_MASK: assert property (mask_wr_s |=> !cpu_irq_req_o)
    else $error("request passed while masked");
  AST_RST: assert property (disable iff (1'b0) !rst_n_i
    |=> !cpu_irq_req_o && !irq_o && reg_rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
endmodule

bind ext_pin_irq ext_pin_irq_props u_ext_pin_irq_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cpu_irq_req_o(cpu_irq_req_o),
  .vector_high_addr_o(vector_high_addr_o), .vector_low_addr_o(vector_low_addr_o),
  .pullup_enable_o(pullup_enable_o), .pin_function_enable_o(pin_function_enable_o),
  .branch_pin_level_o(branch_pin_level_o),
  .port_a_bit_two_force_zero_o(port_a_bit_two_force_zero_o), .irq_o(irq_o));

// ===== tb/irq_src_model.sv
/* open-drain source on the interrupt pin
   assumes the pullup enable comes from the block */
`timescale 1ns/100ps
module irq_src_model (
  // clock and command
  input  wire logic core_clk_i,
  input  wire logic drive_low_i,
  input  wire logic pullup_en_i,
  // pin
  output logic      irq_n_pin_o
);
  logic float_r;
  initial float_r = 1'b0;
  // released pin without pullup floats
  always @(posedge core_clk_i) float_r <= ~float_r;
  assign irq_n_pin_o = drive_low_i ? 1'b0 : (pullup_en_i ? 1'b1 : float_r);
endmodule

// ===== tb/external_pin_interrupt_latch_tb_top.sv
/* self-checking bench for ext_pin_irq with a pin source model
   assumes 100 MHz clock, registered read data */
`timescale 1ns/100ps
module external_pin_interrupt_latch_tb_top;
  import ext_irq_pkg::*;
  logic        clk, rst_n, wr, rd, vf_ack, brk, drv_low, pin_n, req, pu, fn, br, pa, irq;
  reg_addr_t   addr;
  reg_byte_t   wdata, rdata, d;
  logic [15:0] vhi, vlo;
  logic [31:0] lfsr_r;
  int          err_count, n_checks, pend, mask, mode, i;
  ext_pin_irq u_ext_pin_irq (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .irq_n_pin_i(pin_n), .vector_fetch_ack_i(vf_ack), .break_state_i(brk),
    .cpu_irq_req_o(req), .vector_high_addr_o(vhi), .vector_low_addr_o(vlo),
    .pullup_enable_o(pu), .pin_function_enable_o(fn), .branch_pin_level_o(br),
    .port_a_bit_two_force_zero_o(pa), .irq_o(irq));
  irq_src_model u_irq_src_model (.core_clk_i(clk), .drive_low_i(drv_low),
    .pullup_en_i(pu), .irq_n_pin_o(pin_n));
  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic reg_byte_t st();
    return {4'h0, pend[0], 1'b0, mask[0], mode[0]};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(reg_addr_t a, reg_byte_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(reg_addr_t a, output reg_byte_t v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_st(string nm);
    rd_reg(8'h1D, d);
    chk(nm, st(), d);
  endtask
  task automatic pin(logic lvl);
    @(posedge clk);
    drv_low <= ~lvl;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic vf_pulse();
    @(posedge clk);
    vf_ack <= 1'b1;
    @(posedge clk);
    vf_ack <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pend = 0;
    mask = 0;
    mode = 0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
  // ----
  // tests
  // ----
  initial begin
    {rst_n, wr, rd, vf_ack, brk, drv_low} = 6'h00;
    addr = 8'h00;
    wdata = 8'h00;
    lfsr_r = 32'h596C;
    do_reset();
    settle();
    chk_st("status reset");
    chk("vec hi", 16'hFFFA, vhi);
    chk("vec lo", 16'hFFFB, vlo);
    chk("pullup", 16'h1, pu);
    chk("branch", 16'h1, br);
    $display("test reset done");
    wr_reg(8'h1E, 8'h01);
    settle();
    chk("pullup off", 16'h0, pu);
    wr_reg(8'h1E, 8'h02);
    settle();
    chk("fn en", 16'h1, fn);
    chk("port bit", 16'h1, pa);
    wr_reg(8'h1D, 8'h04);
    chk_st("after enable");
    $display("test config done");
    pin(0);
    pend = 1;
    chk_st("edge latch");
    chk("req", 16'h1, req);
    chk("branch low", 16'h0, br);
    pin(1);
    chk_st("edge hold");
    wr_reg(8'h1D, 8'h04);
    pend = 0;
    chk_st("ack clr");
    pin(0);
    pend = 1;
    chk_st("relatch");
    wr_reg(8'h1D, 8'h02);
    mask = 1;
    settle();
    chk("req masked", 16'h0, req);
    chk_st("masked pend");
    vf_pulse();
    pend = 0;
    chk_st("vf clr");
    pin(1);
    wr_reg(8'h1D, 8'h01);
    mask = 0;
    mode = 1;
    pin(0);
    pend = 1;
    wr_reg(8'h1D, 8'h05);
    chk_st("level low ack");
    pin(1);
    pend = 0;
    chk_st("level high");
    pin(0);
    pin(1);
    pend = 1;
    chk_st("level wait ack");
    vf_pulse();
    pend = 0;
    chk_st("level vf");
    $display("test latch done");
    wr_reg(8'h1D, 8'h00);
    mode = 0;
    pin(0);
    pend = 1;
    brk <= 1'b1;
    wr_reg(8'h1D, 8'h04);
    chk_st("break protect");
    wr_reg(8'h20, 8'h80);
    wr_reg(8'h1D, 8'h04);
    pend = 0;
    brk <= 1'b0;
    settle();
    chk_st("break clear");
    wr_reg(8'h20, 8'h00);
    pin(1);
    wr_reg(8'h21, 8'hFF);
    wr_reg(8'h22, 8'h01);
    pin(0);
    settle();
    chk("irq", 16'h1, irq);
    rd_reg(8'h21, d);
    chk("ev status", 16'h01, d);
    wr_reg(8'h21, 8'h01);
    settle();
    chk("irq clr", 16'h0, irq);
    wr_reg(8'h22, 8'h00);
    pin(1);
    pin(0);
    chk("irq masked", 16'h0, irq);
    wr_reg(8'h1D, 8'h04);
    pin(1);
    rd_reg(8'h30, d);
    chk("unmapped", 16'h00, d);
    $display("test events done");
    for (i = 0; i < 4; i++) begin
      lfsr_r = lfsr(lfsr_r);
      wr_reg(8'h1D, lfsr_r[15:8]);
      mask = lfsr_r[9];
      mode = lfsr_r[8];
      chk_st("rand rw");
    end
    wr_reg(8'h1D, 8'h01);
    mask = 0;
    mode = 1;
    pin(0);
    pend = 1;
    chk_st("level pend");
    do_reset();
    settle();
    chk_st("mid reset");
    $display("test random done");
    stop_test();
  end
endmodule
